/* File: rtl/dcff_flag_ctrl.sv */
// Implementation choices: the address map and register access over APB.
`timescale 1ns/1ns
`default_nettype none

module dcff_flag_ctrl
  import dcff_pkg::*;
(
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst_b,
  // apb slave
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [DCFF_PADDR_W-1:0] paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  // writer side
  input  wire logic                    wen_n,
  input  wire logic [DCFF_DATA_W-1:0]  wdata,
  // reader side
  input  wire logic                    ren_n,
  input  wire logic                    output_en_n,
  output logic      [DCFF_DATA_W-1:0]  rdata,
  output logic                         rdata_oe,
  // control pins
  input  wire logic                    offset_load_n,
  input  wire logic                    device_reset_n,
  input  wire logic                    chain_head_or_replay,
  // cascade
  input  wire logic                    write_cascade_in,
  input  wire logic                    read_cascade_in,
  output logic                         write_cascade_out_or_half,
  output logic                         read_cascade_out,
  // status pins
  output dcff_flags_t                  flags
);

  // ============================================================
  // storage and pointers
  logic [DCFF_DATA_W-1:0] mem [0:DCFF_DEPTH-1];
  logic [DCFF_PW-1:0]     wptr_q, rptr_q, wptr_d, rptr_d;
  logic [DCFF_PW-1:0]     wgray_q, rgray_q;
  logic [DCFF_PW-1:0]     wgray_s1_q, wgray_s2_q, rgray_s1_q, rgray_s2_q;
  logic [DCFF_PW-1:0]     wview, rview;
  logic [DCFF_PW-1:0]     cnt_true, cnt_rd, cnt_wr, cnt_sel_ae, cnt_sel_af;
  logic [1:0]             ctrl_q;
  logic [17:0]            ae_off_q, af_off_q;
  logic                   ld_wsel_q, ld_rsel_q;
  logic                   wtok_q, rtok_q, head_q;
  logic                   wr_ok, rd_ok, ld_wr, ld_rd, casc, async_mode;
  logic                   wci_q, rci_q, replay_q, replay_go;
  logic                   wpass, rpass;
  logic                   half_q, wxo_pulse_q;
  logic                   apb_go;

  assign casc       = ctrl_q[DCFF_CTRL_CASC_BIT];
  assign async_mode = ctrl_q[DCFF_CTRL_ASYNC_BIT];

  function automatic logic [DCFF_PW-1:0] gray2bin(input logic [DCFF_PW-1:0] g);
    logic [DCFF_PW-1:0] b;
    b = '0;
    b[DCFF_PW-1] = g[DCFF_PW-1];
    for (int i = DCFF_PW - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

  // ============================================================
  // access qualification
  // the flags gating these are the registered, conservative views
  assign wr_ok = ~wen_n & offset_load_n & flags.full_flag_n & (wtok_q | ~casc);
  assign rd_ok = ~ren_n & offset_load_n & flags.empty_flag_n & (rtok_q | ~casc);
  assign ld_wr = ~wen_n & ~offset_load_n;
  assign ld_rd = ~ren_n & ~offset_load_n;

  // replay only outside a chain, where the pin is a free strobe
  assign replay_go = ~casc & chain_head_or_replay & ~replay_q;

  assign wptr_d = wptr_q + DCFF_PW'(wr_ok);
  assign rptr_d = replay_go ? '0 : rptr_q + DCFF_PW'(rd_ok);

  // ============================================================
  // pointers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wptr_q  <= '0;
      rptr_q  <= '0;
      wgray_q <= '0;
      rgray_q <= '0;
    end else if (!device_reset_n) begin
      wptr_q  <= '0;
      rptr_q  <= '0;
      wgray_q <= '0;
      rgray_q <= '0;
    end else begin
      wptr_q  <= wptr_d;
      rptr_q  <= rptr_d;
      wgray_q <= wptr_d ^ (wptr_d >> 1);
      rgray_q <= rptr_d ^ (rptr_d >> 1);
    end
  end

  // gray pointers pass through two flops before the other side uses them
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wgray_s1_q <= '0;
      wgray_s2_q <= '0;
      rgray_s1_q <= '0;
      rgray_s2_q <= '0;
    end else begin
      wgray_s1_q <= wgray_q;
      wgray_s2_q <= wgray_s1_q;
      rgray_s1_q <= rgray_q;
      rgray_s2_q <= rgray_s1_q;
    end
  end

  assign wview    = gray2bin(wgray_s2_q);
  assign rview    = gray2bin(rgray_s2_q);
  assign cnt_true = wptr_d - rptr_d;
  assign cnt_rd   = wview - rptr_d;
  assign cnt_wr   = wptr_d - rview;
  // async mode follows the true level, sync mode each side's own view
  assign cnt_sel_ae = async_mode ? cnt_true : cnt_rd;
  assign cnt_sel_af = async_mode ? cnt_true : cnt_wr;

  always_ff @(posedge clk) begin
    if (wr_ok) begin
      mem[wptr_q[DCFF_AW-1:0]] <= wdata;
    end
  end

  // ============================================================
  // flags
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flags  <= '{empty_flag_n: 1'b0, full_flag_n: 1'b1, almost_empty_n: 1'b0, almost_full_n: 1'b1};
      half_q <= 1'b0;
    end else if (!device_reset_n) begin
      flags  <= '{empty_flag_n: 1'b0, full_flag_n: 1'b1, almost_empty_n: 1'b0, almost_full_n: 1'b1};
      half_q <= 1'b0;
    end else begin
      // a late write only delays leaving empty; never a false non-empty
      flags.empty_flag_n   <= (cnt_rd != '0);
      flags.full_flag_n    <= (cnt_wr != DCFF_DEPTH);
      flags.almost_empty_n <= ({2'b00, cnt_sel_ae} > ae_off_q);
      flags.almost_full_n  <= ({2'b00, cnt_sel_af} < ({2'b00, DCFF_DEPTH} - af_off_q));
      half_q               <= (cnt_true > DCFF_HALF);
    end
  end

  // ============================================================
  // read data, offset register access and output enable
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata     <= '0;
      ld_rsel_q <= 1'b0;
    end else if (!device_reset_n) begin
      rdata     <= '0;
      ld_rsel_q <= 1'b0;
    end else if (ld_rd) begin
      rdata     <= ld_rsel_q ? af_off_q : ae_off_q;
      ld_rsel_q <= ~ld_rsel_q;
    end else if (rd_ok) begin
      rdata     <= mem[rptr_q[DCFF_AW-1:0]];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_oe <= 1'b0;
    end else begin
      rdata_oe <= ~output_en_n;
    end
  end

  // offsets load alternately: empty offset first, then full offset
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ae_off_q  <= DCFF_AE_OFF_RST;
      af_off_q  <= DCFF_AF_OFF_RST;
      ld_wsel_q <= 1'b0;
    end else if (!device_reset_n) begin
      ae_off_q  <= DCFF_AE_OFF_RST;
      af_off_q  <= DCFF_AF_OFF_RST;
      ld_wsel_q <= 1'b0;
    end else if (ld_wr) begin
      ld_wsel_q <= ~ld_wsel_q;
      if (ld_wsel_q) begin
        af_off_q <= wdata;
      end else begin
        ae_off_q <= wdata;
      end
    end else if (apb_go && pwrite && paddr == DCFF_AE_OFF) begin
      ae_off_q <= pwdata[17:0];
    end else if (apb_go && pwrite && paddr == DCFF_AF_OFF) begin
      af_off_q <= pwdata[17:0];
    end
  end

  // ============================================================
  // depth cascade: tokens pass as one-cycle low pulses
  assign wpass = casc & wtok_q & wr_ok & (cnt_wr == DCFF_DEPTH - 16'h0001);
  assign rpass = casc & rtok_q & rd_ok & ~wtok_q & (cnt_rd == 16'h0001);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wci_q    <= 1'b1;
      rci_q    <= 1'b1;
      replay_q <= 1'b0;
    end else begin
      wci_q    <= write_cascade_in;
      rci_q    <= read_cascade_in;
      replay_q <= chain_head_or_replay;
    end
  end

  // head strap caught while the device reset pin is held
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      head_q <= 1'b0;
      wtok_q <= 1'b1;
      rtok_q <= 1'b1;
    end else if (!device_reset_n) begin
      head_q <= ~chain_head_or_replay;
      wtok_q <= ~chain_head_or_replay;
      rtok_q <= ~chain_head_or_replay;
    end else if (casc) begin
      if (wpass) begin
        wtok_q <= 1'b0;
      end else if (wci_q && !write_cascade_in) begin
        wtok_q <= 1'b1;
      end
      if (rpass) begin
        rtok_q <= 1'b0;
      end else if (rci_q && !read_cascade_in) begin
        rtok_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wxo_pulse_q      <= 1'b1;
      read_cascade_out <= 1'b1;
    end else begin
      wxo_pulse_q      <= ~wpass;
      read_cascade_out <= ~rpass;
    end
  end

  // half flag is active low like the other status pins
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      write_cascade_out_or_half <= 1'b1;
    end else if (casc) begin
      write_cascade_out_or_half <= ~wpass;
    end else begin
      write_cascade_out_or_half <= ~((cnt_true > DCFF_HALF) & device_reset_n);
    end
  end

  // ============================================================
  // apb slave: one wait state, answer registered
  assign apb_go = psel & penable & pready;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~(paddr == DCFF_CTRL || paddr == DCFF_STATUS ||
                                             paddr == DCFF_AE_OFF || paddr == DCFF_AF_OFF);
      prdata  <= '0;
      if (psel && penable && !pready && !pwrite) begin
        if (paddr == DCFF_CTRL) begin
          prdata <= {30'h00000000, ctrl_q};
        end else if (paddr == DCFF_STATUS) begin
          prdata <= {cnt_true, 9'h000, rtok_q, wtok_q, half_q, ~flags.almost_full_n,
                     ~flags.almost_empty_n, ~flags.full_flag_n, ~flags.empty_flag_n};
        end else if (paddr == DCFF_AE_OFF) begin
          prdata <= {14'h0000, ae_off_q};
        end else if (paddr == DCFF_AF_OFF) begin
          prdata <= {14'h0000, af_off_q};
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q <= DCFF_CTRL_RST;
    end else if (apb_go && pwrite && paddr == DCFF_CTRL) begin
      ctrl_q <= pwdata[1:0];
    end
  end

endmodule

`default_nettype wire

/* File: rtl/dcff_pkg.sv */
package dcff_pkg;

  // ============================================================
  // storage geometry
  localparam int          DCFF_DATA_W  = 18;
  localparam int          DCFF_AW      = 15;
  localparam int          DCFF_PW      = DCFF_AW + 1;
  localparam logic [15:0] DCFF_DEPTH   = 16'h8000;
  localparam logic [15:0] DCFF_HALF    = 16'h4000;

  // ============================================================
  // apb register map (byte addresses)
  localparam int          DCFF_PADDR_W = 12;
  localparam logic [11:0] DCFF_CTRL    = 12'h000;
  localparam logic [11:0] DCFF_STATUS  = 12'h004;
  localparam logic [11:0] DCFF_AE_OFF  = 12'h008;
  localparam logic [11:0] DCFF_AF_OFF  = 12'h00C;

  // control fields
  localparam int          DCFF_CTRL_ASYNC_BIT = 0;
  localparam int          DCFF_CTRL_CASC_BIT  = 1;
  localparam logic [1:0]  DCFF_CTRL_RST       = 2'h0;

  // status fields
  localparam int          DCFF_ST_EMPTY  = 0;
  localparam int          DCFF_ST_FULL   = 1;
  localparam int          DCFF_ST_AE     = 2;
  localparam int          DCFF_ST_AF     = 3;
  localparam int          DCFF_ST_HALF   = 4;
  localparam int          DCFF_ST_WTOK   = 5;
  localparam int          DCFF_ST_RTOK   = 6;
  localparam int          DCFF_ST_CNT    = 16;

  // offset register reset values
  localparam logic [17:0] DCFF_AE_OFF_RST = 18'h0007F;
  localparam logic [17:0] DCFF_AF_OFF_RST = 18'h0007F;

  // ============================================================
  // status pins, all active low
  typedef struct packed {
    logic empty_flag_n;
    logic full_flag_n;
    logic almost_empty_n;
    logic almost_full_n;
  } dcff_flags_t;

endpackage

/* File: tb/dcff_flag_ctrl_properties.sv */
`timescale 1ns/1ns
`default_nettype none
// ============================================================
// port properties of the flag controller
module dcff_checker
  import dcff_pkg::*;
(
  // clock and reset
  input wire logic                   clk,
  input wire logic                   rst_b,
  // apb
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pready,
  input wire logic                   pslverr,
  // pins
  input wire logic                   ren_n,
  input wire logic                   offset_load_n,
  input wire logic                   device_reset_n,
  input wire logic                   output_en_n,
  input wire logic [DCFF_DATA_W-1:0] rdata,
  input wire logic                   rdata_oe,
  input wire dcff_flags_t            flags
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready stood longer than one cycle");
  ready_answer_a: assert property (psel && penable && !pready |=> pready)
    else $error("access phase not answered after one wait state");
  slverr_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  reset_empty_a: assert property (!device_reset_n |=> !flags.empty_flag_n && flags.full_flag_n)
    else $error("device reset did not give the empty state");
  flag_exclusive_a: assert property (!(!flags.empty_flag_n && !flags.full_flag_n))
    else $error("empty and full flags low together");
  empty_almost_a: assert property (!flags.empty_flag_n |-> !flags.almost_empty_n)
    else $error("empty without almost empty");
  oe_follow_a: assert property (1'b1 |=> rdata_oe != $past(output_en_n))
    else $error("output enable not followed one cycle later");
  empty_read_a: assert property (!flags.empty_flag_n && !ren_n && offset_load_n && device_reset_n
    |=> $stable(rdata))
    else $error("read while empty changed the output word");
  rdata_cause_a: assert property ($changed(rdata) |-> !$past(ren_n) || !$past(device_reset_n))
    else $error("output word changed without a read");
endmodule

bind dcff_flag_ctrl dcff_checker u_chk (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .ren_n(ren_n), .offset_load_n(offset_load_n),
  .device_reset_n(device_reset_n), .output_en_n(output_en_n), .rdata(rdata), .rdata_oe(rdata_oe),
  .flags(flags));
`default_nettype wire

/* File: tb/dcff_far_end.sv */
`timescale 1ns/1ns
`default_nettype none
// ============================================================
// writer and reader logic on the far side of the buffer
module dcff_far_end (
  // clock
  input  wire logic        clk,
  // requests from the bench
  input  wire logic        wr_req,
  input  wire logic        rd_req,
  input  wire logic        ld_req,
  input  wire logic [17:0] wr_word,
  // pins toward the buffer
  output logic             wen_n = 1'b1,
  output logic             ren_n = 1'b1,
  output logic             offset_load_n = 1'b1,
  output logic [17:0]      wdata = 18'h00000
);
  always_ff @(posedge clk) begin
    wen_n         <= !wr_req;
    ren_n         <= !rd_req;
    offset_load_n <= !ld_req;
    // idle data flips so a stale word never passes for a fresh one
    wdata         <= wr_req ? wr_word : ~wdata;
  end
endmodule
`default_nettype wire

/* File: tb/dcff_flag_ctrl_bench.sv */
`timescale 1ns/1ns
`default_nettype none
module dcff_flag_ctrl_bench;
  import dcff_pkg::*;
  logic clk = 1'b0, rst_b = 1'b0, device_reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, prdata, ap_rd;
  logic pready, pslverr, ap_err, rdata_oe, half_n, wen_n, ren_n, offset_load_n, read_cascade_out;
  logic output_en_n = 1'b1, wr_req = 1'b0, rd_req = 1'b0, ld_req = 1'b0, replay = 1'b0;
  logic [17:0] wr_word = 18'h00000, wdata, rdata, exp_rd;
  // every word since the last device reset, so a replay can rewind to the first
  logic [17:0] hist[$];
  int ridx = 0;
  bit replay_prev = 0;
  dcff_flags_t flags;
  int seed = 23114, bad_count = 0, num_checks = 0, cycles = 0, cnt = 0, ae_off, af_off, i;
  bit wtog, rtog, pend = 0;
  int stops[7] = '{6, 7, 16384, 16385, 32762, 32763, 32769};

  always #2 clk = ~clk;
  // the cascade pins sit at their standalone levels
  dcff_flag_ctrl dut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .wen_n(wen_n),
    .wdata(wdata), .ren_n(ren_n), .output_en_n(output_en_n), .rdata(rdata), .rdata_oe(rdata_oe),
    .offset_load_n(offset_load_n), .device_reset_n(device_reset_n), .chain_head_or_replay(replay),
    .write_cascade_in(1'b0), .read_cascade_in(1'b0), .write_cascade_out_or_half(half_n),
    .read_cascade_out(read_cascade_out), .flags(flags));
  dcff_far_end far (.clk(clk), .wr_req(wr_req), .rd_req(rd_req), .ld_req(ld_req), .wr_word(wr_word),
    .wen_n(wen_n), .ren_n(ren_n), .offset_load_n(offset_load_n), .wdata(wdata));

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    ap_rd = prdata;
    ap_err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  // reference model of contents and offsets, fed from the pins
  always @(posedge clk) begin
    cycles++;
    if (cycles == 95000) begin
      bad_count++;
      print_verdict();
    end
    if (!device_reset_n) begin
      cnt = 0; hist.delete(); ridx = 0; ae_off = 'h7F; af_off = 'h7F; wtog = 0; rtog = 0;
    end else if (!offset_load_n) begin
      if (!wen_n) begin
        if (wtog) af_off = wdata; else ae_off = wdata;
        wtog = !wtog;
      end
      if (!ren_n) begin
        exp_rd = rtog ? af_off[17:0] : ae_off[17:0];
        rtog = !rtog; pend = 1;
      end
    end else begin
      if (replay && !replay_prev) ridx = 0;
      else if (!ren_n && cnt > 0) begin exp_rd = hist[ridx]; ridx++; pend = 1; end
      if (!wen_n && cnt < 32768) hist.push_back(wdata);
      cnt = hist.size() - ridx;
    end
    replay_prev = replay;
  end
  always @(negedge clk) if (pend) begin pend = 0; check("rdata", rdata, exp_rd); end

  task automatic check_flags;
    repeat (8) @(posedge clk);
    @(negedge clk);
    check("empty", flags.empty_flag_n, cnt != 0);
    check("full", flags.full_flag_n, cnt != 32768);
    check("almost_empty", flags.almost_empty_n, cnt > ae_off);
    check("almost_full", flags.almost_full_n, cnt < 32768 - af_off);
    check("half", half_n, cnt <= 16384);
    check("oe", rdata_oe, !output_en_n);
    check("rxo", read_cascade_out, 1'b1);
  endtask

  task automatic fill(input int n);
    repeat (n) begin
      @(posedge clk);
      wr_req <= 1'b1; wr_word <= 18'($random(seed));
    end
    @(posedge clk);
    wr_req <= 1'b0;
    check_flags();
  endtask

  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1; device_reset_n <= 1'b1;
    check_flags();
    apb(1'b0, DCFF_CTRL, 0); check("ctrl", ap_rd, 0);
    apb(1'b0, DCFF_AE_OFF, 0); check("ae_off", ap_rd, DCFF_AE_OFF_RST);
    apb(1'b0, 12'h010, 0); check("unmapped", ap_err, 1'b1);
    apb(1'b1, DCFF_STATUS, 32'h0000FFFF); apb(1'b0, DCFF_STATUS, 0);
    check("status", {ap_rd[31:16], ap_rd[4:0]}, {16'h0000, 5'h05});
    output_en_n <= 1'b0;
    @(posedge clk); ld_req <= 1'b1; wr_req <= 1'b1; wr_word <= 18'h00006;
    @(posedge clk); wr_word <= 18'h00005;
    @(posedge clk); wr_req <= 1'b0; rd_req <= 1'b1;
    repeat (2) @(posedge clk);
    rd_req <= 1'b0; ld_req <= 1'b0;
    apb(1'b0, DCFF_AE_OFF, 0); check("ae_off_load", ap_rd, ae_off);
    for (i = 0; i < 7; i++) fill(stops[i] - (i == 0 ? 0 : stops[i-1]));
    // the reader stalls at random while draining
    while (cnt != 0) begin
      @(posedge clk);
      rd_req <= ($random(seed) & 7) != 0;
    end
    @(posedge clk); rd_req <= 1'b1;
    repeat (4) @(posedge clk);
    rd_req <= 1'b0;
    check_flags();
    apb(1'b1, DCFF_CTRL, 1); apb(1'b0, DCFF_CTRL, 0); check("ctrl_async", ap_rd, 1);
    fill(5);
    output_en_n <= 1'b1;
    device_reset_n <= 1'b0;
    repeat (3) @(posedge clk);
    device_reset_n <= 1'b1;
    check_flags();
    apb(1'b0, DCFF_AF_OFF, 0); check("af_off", ap_rd, DCFF_AF_OFF_RST);
    // replay: read one word, strobe the replay pin, then read all three from the start
    fill(3);
    @(posedge clk); rd_req <= 1'b1;
    @(posedge clk); rd_req <= 1'b0;
    repeat (4) @(posedge clk);
    replay <= 1'b1;
    @(posedge clk); replay <= 1'b0;
    repeat (8) @(posedge clk);
    rd_req <= 1'b1;
    repeat (3) @(posedge clk);
    rd_req <= 1'b0;
    check_flags();
    print_verdict();
  end
endmodule
`default_nettype wire
